// ---- hdl/cpio_decode.sv ----
// instruction decoder: maps the two instruction fields to one operation
// assumes fields are stable during the instruction cycle strobe
`timescale 1ns/1ps
`include "cpio_params.svh"
module cpio_decode (
    input wire logic [15:0] field0,
    input wire logic [15:0] field1,
    output cpio_pkg::cpio_op_type op
);
    import cpio_pkg::*;
    // purely combinational; store group lives in field 0, channel group in field 1
    always_comb
    begin
        op = CPIO_NONE;
        if (field1 == 16'h0000 && field0[15] == 1'b0)
        begin
            // store group, register number in bits 14:8
            case (field0[7:0])
                `CPIO_OP_STORE_PAIR: op = CPIO_STORE_PAIR;
                `CPIO_OP_STORE_FIRST: op = CPIO_STORE_FIRST;
                `CPIO_OP_STORE_SECOND: op = CPIO_STORE_SECOND;
                default: op = CPIO_NONE;
            endcase
        end
        else if (field0 == 16'h0000)
        begin
            // channel group, exact opcodes before the wider command pattern
            if (field1[15:8] == `CPIO_OP_BUF_FIRST && field1[7:0] == 8'h00)
                op = CPIO_BUF_FIRST;
            else if (field1[15:8] == `CPIO_OP_BUF_SECOND && field1[7:0] == 8'h00)
                op = CPIO_BUF_SECOND;
            else if (field1[15:8] == `CPIO_OP_BUF_IMM_HIGH)
                op = CPIO_BUF_IMM_HIGH;
            else if (field1[15:8] == `CPIO_OP_BUF_IMM_LOW)
                op = CPIO_BUF_IMM_LOW;
            else if (field1[15:8] == `CPIO_OP_BUF_READBACK && field1[7:0] == 8'h00)
                op = CPIO_BUF_READBACK;
            else if (field1[15:9] == `CPIO_OP_BUF_SEND)
                op = CPIO_BUF_SEND;
            else if (field1[15:12] == `CPIO_OP_CMD_LOAD)
                op = CPIO_CMD_LOAD;
            else
                op = CPIO_NONE;
        end
    end
endmodule : cpio_decode

// ---- hdl/cpio_exec.sv ----
// execution logic for general register stores and channel buffer ops
// assumes one instruction cycle per ref_clk edge qualified by instr_valid
`timescale 1ns/1ps
`include "cpio_params.svh"
module cpio_exec #(
    parameter int REG_COUNT = `CPIO_REG_COUNT
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic instr_valid,
    input wire logic [15:0] field0,
    input wire logic [15:0] field1,
    input wire logic [15:0] data_bus_first,
    input wire logic [15:0] data_bus_second,
    input wire logic [6:0] reg_rd_index,
    output logic [15:0] reg_rd_data,
    output logic [11:0] addr_bus_out,
    output logic addr_bus_valid,
    output logic [15:0] readback_word,
    output logic readback_drive,
    output logic [15:0] output_data_buffer,
    output logic device_send,
    output logic [8:0] device_cmd_addr,
    output logic [15:0] device_data,
    output logic cmd_with_data
);
    import cpio_pkg::*;

    cpio_op_type op; // decoded operation, valid while instr_valid
    cpio_op_type op_q; // operation in the cycle just executed
    logic [15:0] regfile_r [REG_COUNT]; // general register file
    logic [15:0] obuf_r; // output data buffer
    logic [6:0] reg_num; // register number from the instruction
    logic [6:0] reg_even; // even register of a pair

    // shared index extraction, used by both pair and single stores
    function automatic logic [6:0] cpio_reg_index(input logic [15:0] f0, input logic pair);
        logic [6:0] idx;
        idx = f0[`CPIO_REG_IDX_LSB +: `CPIO_REG_IDX_W];
        if (pair)
            idx[0] = 1'b0;
        return idx;
    endfunction : cpio_reg_index

    cpio_decode u_decode (
        .field0(field0),
        .field1(field1),
        .op(op)
    );

    assign reg_num = cpio_reg_index(field0, 1'b0);
    assign reg_even = cpio_reg_index(field0, 1'b1);

    // general register writes; no reset, the file holds program data
    always_ff @(posedge ref_clk)
    begin
        if (instr_valid)
        begin
            case (op)
                CPIO_STORE_PAIR:
                begin
                    regfile_r[reg_even] <= data_bus_first;
                    regfile_r[reg_even + 7'h01] <= data_bus_second;
                end
                CPIO_STORE_FIRST: regfile_r[reg_num] <= data_bus_first;
                CPIO_STORE_SECOND: regfile_r[reg_num] <= data_bus_second;
                default: ;
            endcase
        end
    end

    // register read port for the rest of the processor
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            reg_rd_data <= 16'h0000;
        else
            reg_rd_data <= regfile_r[reg_rd_index];
    end

    // output data buffer; holds between loads so one value feeds many sends
    // buffer holds
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            obuf_r <= `CPIO_BUF_RESET;
        else if (instr_valid)
        begin
            case (op)
                CPIO_BUF_FIRST: obuf_r <= data_bus_first;
                CPIO_BUF_SECOND: obuf_r <= data_bus_second;
                CPIO_BUF_IMM_HIGH: obuf_r[15:8] <= field1[7:0];
                CPIO_BUF_IMM_LOW: obuf_r[7:0] <= field1[7:0];
                default: ;
            endcase
        end
    end
    assign output_data_buffer = obuf_r;

    // address multibus drive; every value taken from the instruction word
    // instruction sourced
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            addr_bus_out <= 12'h000;
            addr_bus_valid <= 1'b0;
            op_q <= CPIO_NONE;
        end
        else
        begin
            op_q <= instr_valid ? op : CPIO_NONE;
            addr_bus_valid <= instr_valid && (op inside {CPIO_CMD_LOAD, CPIO_BUF_FIRST,
                CPIO_BUF_SECOND, CPIO_BUF_IMM_HIGH, CPIO_BUF_IMM_LOW, CPIO_BUF_SEND,
                CPIO_BUF_READBACK});
            case (op)
                CPIO_CMD_LOAD: addr_bus_out <= field1[11:0];
                CPIO_BUF_IMM_HIGH, CPIO_BUF_IMM_LOW: addr_bus_out <= {4'h0, field1[7:0]};
                CPIO_BUF_SEND: addr_bus_out <= {3'h0, field1[8:0]};
                default: addr_bus_out <= field1[11:0];
            endcase
        end
    end

    // a command word flags whether it pairs with data on the data bus
    // command with data
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            cmd_with_data <= 1'b0;
        else if (instr_valid && op == CPIO_CMD_LOAD)
            cmd_with_data <= (data_bus_first != 16'h0000) || (data_bus_second != 16'h0000);
        else
            cmd_with_data <= 1'b0;
    end

    // readback drives the second transaction one cycle after the instruction
    // buffer readback
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            readback_word <= 16'h0000;
        else if (instr_valid && op == CPIO_BUF_READBACK)
            readback_word <= obuf_r;
    end
    assign readback_drive = (op_q == CPIO_BUF_READBACK);

    // send to the device controller: command, address and held buffer
    // buffer send
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            device_send <= 1'b0;
            device_cmd_addr <= 9'h000;
            device_data <= 16'h0000;
        end
        else
        begin
            device_send <= instr_valid && op == CPIO_BUF_SEND;
            if (instr_valid && op == CPIO_BUF_SEND)
            begin
                device_cmd_addr <= field1[8:0];
                device_data <= obuf_r;
            end
        end
    end

    // pair store lands the second word of the pair in the next cycle
    a_pair_store: assert property (@(posedge ref_clk) disable iff (rst)
        instr_valid && op == CPIO_STORE_PAIR |=>
            regfile_r[$past(reg_even) + 7'h01] == $past(data_bus_second))
        else $error("pair second word not stored");
    a_pair_even: assert property (@(posedge ref_clk) disable iff (rst)
        reg_even[0] == 1'b0 && reg_even[6:1] == field0[14:9])
        else $error("pair base not even");
    a_first_store: assert property (@(posedge ref_clk) disable iff (rst)
        instr_valid && op == CPIO_STORE_FIRST |=>
            regfile_r[$past(reg_num)] == $past(data_bus_first))
        else $error("first word not stored");
    a_second_store: assert property (@(posedge ref_clk) disable iff (rst)
        instr_valid && op == CPIO_STORE_SECOND |=>
            regfile_r[$past(reg_num)] == $past(data_bus_second))
        else $error("second word not stored");
    a_cmd_drive: assert property (@(posedge ref_clk) disable iff (rst)
        instr_valid && op == CPIO_CMD_LOAD |=>
            addr_bus_valid && addr_bus_out == $past(field1[11:0]))
        else $error("command not on address bus");
    a_buf_first: assert property (@(posedge ref_clk) disable iff (rst)
        instr_valid && op == CPIO_BUF_FIRST |=> obuf_r == $past(data_bus_first))
        else $error("buffer missed first word");
    a_buf_second: assert property (@(posedge ref_clk) disable iff (rst)
        instr_valid && op == CPIO_BUF_SECOND |=> obuf_r == $past(data_bus_second))
        else $error("buffer missed second word");
    a_buf_hold: assert property (@(posedge ref_clk) disable iff (rst)
        !instr_valid |=> $stable(obuf_r))
        else $error("buffer changed without load");
    a_imm_high: assert property (@(posedge ref_clk) disable iff (rst)
        instr_valid && op == CPIO_BUF_IMM_HIGH |=>
            obuf_r == {$past(field1[7:0]), $past(obuf_r[7:0])})
        else $error("high byte load wrong");
    a_imm_low: assert property (@(posedge ref_clk) disable iff (rst)
        instr_valid && op == CPIO_BUF_IMM_LOW |=>
            obuf_r == {$past(obuf_r[15:8]), $past(field1[7:0])})
        else $error("low byte load wrong");
    a_readback_drive: assert property (@(posedge ref_clk) disable iff (rst)
        instr_valid && op == CPIO_BUF_READBACK |=>
            readback_drive && readback_word == $past(obuf_r))
        else $error("readback not driven");
    a_send_data: assert property (@(posedge ref_clk) disable iff (rst)
        instr_valid && op == CPIO_BUF_SEND |=> device_send && device_data == $past(obuf_r))
        else $error("send lost buffer");
endmodule : cpio_exec

// ---- shared/cpio_params.svh ----
// constants for the control processor store and i/o buffer execution block
// assumes 16-bit instruction fields and 16-bit multibus words
`ifndef CPIO_PARAMS_SVH
`define CPIO_PARAMS_SVH
`define CPIO_WORD_W 16
`define CPIO_REG_COUNT 128
`define CPIO_REG_IDX_W 7
`define CPIO_REG_IDX_LSB 8
`define CPIO_CMD_W 12
`define CPIO_IMM_W 8
`define CPIO_ADDR_BUS_W 12
// field 0 opcodes (bits 7:0) for the store group
`define CPIO_OP_STORE_PAIR 8'h07
`define CPIO_OP_STORE_FIRST 8'h06
`define CPIO_OP_STORE_SECOND 8'h05
// field 1 opcodes (bits 15:8, 15:9 for send, 15:12 for command load) for the channel group, field 0 zero
`define CPIO_OP_CMD_LOAD 4'h8
`define CPIO_OP_BUF_FIRST 8'h84
`define CPIO_OP_BUF_SECOND 8'h85
`define CPIO_OP_BUF_IMM_HIGH 8'h88
`define CPIO_OP_BUF_IMM_LOW 8'h89
`define CPIO_OP_BUF_READBACK 8'h16
`define CPIO_OP_BUF_SEND 7'h45
`define CPIO_BUF_RESET 16'h0000
`endif

// ---- shared/cpio_pkg.sv ----
// types for the control processor store and i/o buffer block
// assumes cpio_params.svh is on the include path
package cpio_pkg;
    // decoded operation of one instruction cycle
    typedef enum logic [3:0] {
        CPIO_NONE,
        CPIO_STORE_PAIR,
        CPIO_STORE_FIRST,
        CPIO_STORE_SECOND,
        CPIO_CMD_LOAD,
        CPIO_BUF_FIRST,
        CPIO_BUF_SECOND,
        CPIO_BUF_IMM_HIGH,
        CPIO_BUF_IMM_LOW,
        CPIO_BUF_READBACK,
        CPIO_BUF_SEND
    } cpio_op_type;
endpackage : cpio_pkg

// ---- verification/cpio_far_model.sv ----
// far side model: remote device controller behind the channel cable
// assumes send pulses last one ref_clk cycle with payload valid alongside
`timescale 1ns/1ps
module cpio_far_model #(
    parameter int CONV_CYCLES = 4
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic device_send,
    input wire logic [8:0] device_cmd_addr,
    input wire logic [15:0] device_data,
    output logic [7:0] send_count,
    output logic [6:0] last_addr,
    output logic [4:0] last_group,
    output logic [15:0] last_data,
    output logic conv_ready
);
    // converter busy count, restarted by each send; a program must wait it out
    // conversion time
    logic [7:0] conv_count;
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            conv_count <= 8'h00;
        else if (device_send)
            conv_count <= 8'(CONV_CYCLES);
        else if (conv_count != 8'h00)
            conv_count <= conv_count - 8'h01;
    end
    assign conv_ready = (conv_count == 8'h00);
    // group table, default address modulo 32; real sites assign freely
    logic [4:0] group_of [0:127];
    initial
    begin
        for (int i = 0; i < 128; i++)
            group_of[i] = 5'(i);
    end
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            send_count <= 8'h00;
            last_addr <= 7'h00;
            last_group <= 5'h00;
            last_data <= 16'h0000;
        end
        else if (device_send)
        begin
            // only the low seven bits select a device, so 128 at most
            send_count <= send_count + 8'h01;
            last_addr <= device_cmd_addr[6:0];
            last_group <= group_of[device_cmd_addr[6:0]];
            last_data <= device_data;
        end
    end
endmodule : cpio_far_model

// ---- verification/tb_control_proc_store_and_io_buffer_ops.sv ----
// self-checking bench for the store and channel buffer execution block
// assumes cpio_params.svh on the include path; inputs change on falling edges
`timescale 1ns/1ps
`include "cpio_params.svh"
module tb_control_proc_store_and_io_buffer_ops;
    import cpio_pkg::*;
    logic ref_clk, rst, instr_valid, addr_bus_valid, readback_drive, device_send;
    logic cmd_with_data, conv_ready;
    logic [15:0] field0, field1, data_bus_first, data_bus_second, reg_rd_data, readback_word;
    logic [15:0] output_data_buffer, device_data, last_data;
    logic [6:0] reg_rd_index, last_addr;
    logic [11:0] addr_bus_out;
    logic [8:0] device_cmd_addr;
    logic [7:0] send_count;
    logic [4:0] last_group;
    int mismatches = 0;
    int n_checks = 0;
    // 20 MHz clock
    initial
    begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    cpio_exec u_dut (.ref_clk(ref_clk), .rst(rst), .instr_valid(instr_valid),
        .field0(field0), .field1(field1), .data_bus_first(data_bus_first),
        .data_bus_second(data_bus_second), .reg_rd_index(reg_rd_index),
        .reg_rd_data(reg_rd_data), .addr_bus_out(addr_bus_out),
        .addr_bus_valid(addr_bus_valid), .readback_word(readback_word),
        .readback_drive(readback_drive), .output_data_buffer(output_data_buffer),
        .device_send(device_send), .device_cmd_addr(device_cmd_addr),
        .device_data(device_data), .cmd_with_data(cmd_with_data));
    cpio_far_model u_far (.ref_clk(ref_clk), .rst(rst), .device_send(device_send),
        .device_cmd_addr(device_cmd_addr), .device_data(device_data),
        .send_count(send_count), .last_addr(last_addr), .last_group(last_group),
        .last_data(last_data), .conv_ready(conv_ready));
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : give_verdict
    task automatic check_word(string what, logic [15:0] exp, logic [15:0] got);
        n_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check_word
    task automatic check_bit(string what, logic exp, logic got);
        n_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("mismatch %s expected %b seen %b", what, exp, got);
        end
    endtask : check_bit
    // entered at a falling edge; leaves at the next one with results settled
    task automatic run_instr(logic [15:0] f0, logic [15:0] f1, logic [15:0] d1, logic [15:0] d2);
        instr_valid = 1'b1;
        field0 = f0;
        field1 = f1;
        data_bus_first = d1;
        data_bus_second = d2;
        @(posedge ref_clk);
        @(negedge ref_clk);
    endtask : run_instr
    task automatic idle();
        instr_valid = 1'b0;
        @(posedge ref_clk);
        @(negedge ref_clk);
    endtask : idle
    // register read port answers one cycle after the index is applied
    task automatic read_gr(logic [6:0] idx, logic [15:0] exp);
        reg_rd_index = idx;
        idle();
        check_word("reg_rd_data", exp, reg_rd_data);
    endtask : read_gr
    task automatic t_reset();
        check_word("buffer", `CPIO_BUF_RESET, output_data_buffer);
        check_bit("addr_bus_valid", 1'b0, addr_bus_valid);
        check_bit("device_send", 1'b0, device_send);
    endtask : t_reset
    // back-to-back stores, odd pair index and the top pair
    task automatic t_store();
        run_instr({1'b0, 7'h05, `CPIO_OP_STORE_PAIR}, 16'h0000, 16'hA5A1, 16'h5A52);
        run_instr({1'b0, 7'h7F, `CPIO_OP_STORE_PAIR}, 16'h0000, 16'h1234, 16'h4321);
        run_instr({1'b0, 7'h09, `CPIO_OP_STORE_FIRST}, 16'h0000, 16'hBEEF, 16'hDEAD);
        run_instr({1'b0, 7'h0A, `CPIO_OP_STORE_SECOND}, 16'h0000, 16'h1111, 16'h2222);
        read_gr(7'h04, 16'hA5A1);
        read_gr(7'h05, 16'h5A52);
        read_gr(7'h7E, 16'h1234);
        read_gr(7'h7F, 16'h4321);
        read_gr(7'h09, 16'hBEEF);
        read_gr(7'h0A, 16'h2222);
    endtask : t_store
    task automatic t_buffer();
        run_instr(16'h0000, {`CPIO_OP_BUF_FIRST, 8'h00}, 16'h1357, 16'hFFFF);
        check_word("buffer", 16'h1357, output_data_buffer);
        check_bit("addr_bus_valid", 1'b1, addr_bus_valid);
        run_instr(16'h0000, {`CPIO_OP_BUF_SECOND, 8'h00}, 16'h0000, 16'h2468);
        check_word("buffer", 16'h2468, output_data_buffer);
        repeat (3) idle();
        check_word("buffer", 16'h2468, output_data_buffer);
    endtask : t_buffer
    // byte loads with busy data lines that must be ignored
    task automatic t_immediate();
        run_instr(16'h0000, {`CPIO_OP_BUF_IMM_HIGH, 8'hC3}, 16'hFFFF, 16'hFFFF);
        check_word("buffer", 16'hC368, output_data_buffer);
        check_word("addr_bus_out", 16'h00C3, {4'h0, addr_bus_out});
        run_instr(16'h0000, {`CPIO_OP_BUF_IMM_LOW, 8'h96}, 16'hFFFF, 16'hFFFF);
        check_word("buffer", 16'hC396, output_data_buffer);
        check_word("addr_bus_out", 16'h0096, {4'h0, addr_bus_out});
        check_bit("addr_bus_valid", 1'b1, addr_bus_valid);
        idle();
    endtask : t_immediate
    task automatic t_readback();
        run_instr(16'h0000, {`CPIO_OP_BUF_READBACK, 8'h00}, 16'h0000, 16'h0000);
        check_bit("readback_drive", 1'b1, readback_drive);
        check_word("readback_word", 16'hC396, readback_word);
        idle();
        check_bit("readback_drive", 1'b0, readback_drive);
    endtask : t_readback
    // one buffer value sent to two devices back to back
    task automatic t_send();
        run_instr(16'h0000, {`CPIO_OP_BUF_SEND, 9'h0A5}, 16'h0000, 16'h0000);
        check_bit("device_send", 1'b1, device_send);
        check_word("device_cmd_addr", 16'h00A5, {7'h00, device_cmd_addr});
        run_instr(16'h0000, {`CPIO_OP_BUF_SEND, 9'h133}, 16'h0000, 16'h0000);
        check_word("device_data", 16'hC396, device_data);
        idle();
        check_bit("device_send", 1'b0, device_send);
        check_word("send_count", 16'h0002, {8'h00, send_count});
        check_word("last_addr", 16'h0033, {9'h000, last_addr});
        check_word("last_group", 16'h0013, {11'h000, last_group});
        // the far converter is busy right after the send; wait a bounded time
        check_bit("conv_ready", 1'b0, conv_ready);
        for (int i = 0; i < 20 && !conv_ready; i++)
            idle();
        check_bit("conv_ready", 1'b1, conv_ready);
        check_word("last_data", 16'hC396, last_data);
    endtask : t_send
    task automatic t_command();
        run_instr(16'h0000, 16'h83A5, 16'h0000, 16'h0000);
        check_word("addr_bus_out", 16'h03A5, {4'h0, addr_bus_out});
        check_bit("addr_bus_valid", 1'b1, addr_bus_valid);
        check_bit("cmd_with_data", 1'b0, cmd_with_data);
        run_instr(16'h0000, 16'h83A5, 16'h0000, 16'h0001);
        check_bit("cmd_with_data", 1'b1, cmd_with_data);
        run_instr(16'h0000, 16'h0300, 16'h7777, 16'h7777);
        check_bit("addr_bus_valid", 1'b0, addr_bus_valid);
        check_word("buffer", 16'hC396, output_data_buffer);
        idle();
    endtask : t_command
    // reset in mid-run clears buffer, read port and far side, then loads work again
    task automatic t_mid_reset();
        rst = 1'b1;
        idle();
        check_word("buffer", `CPIO_BUF_RESET, output_data_buffer);
        check_word("reg_rd_data", 16'h0000, reg_rd_data);
        check_word("send_count", 16'h0000, {8'h00, send_count});
        rst = 1'b0;
        run_instr(16'h0000, {`CPIO_OP_BUF_IMM_LOW, 8'h5A}, 16'h0000, 16'h0000);
        check_word("buffer", 16'h005A, output_data_buffer);
        idle();
    endtask : t_mid_reset
    // hang guard: the whole run needs far fewer cycles
    initial
    begin
        repeat (5000) @(posedge ref_clk);
        mismatches++;
        $display("mismatch run_length expected finish seen hang");
        give_verdict();
    end
    initial
    begin
        rst = 1'b1;
        instr_valid = 1'b0;
        field0 = 16'h0000;
        field1 = 16'h0000;
        data_bus_first = 16'h0000;
        data_bus_second = 16'h0000;
        reg_rd_index = 7'h00;
        repeat (10) @(posedge ref_clk);
        @(negedge ref_clk);
        rst = 1'b0;
        t_reset();
        t_store();
        t_buffer();
        t_immediate();
        t_readback();
        t_send();
        t_command();
        t_mid_reset();
        give_verdict();
    end
endmodule : tb_control_proc_store_and_io_buffer_ops
